//--- afe_config_regs.sv
// Configuration bank: main configuration 4 and 5, soft reset, revision, red gain and offsets.
//
// How it works
// - Config4 bit 7 connects clamp voltage divider.
// - Config4 bit 6 powers down reference buffer.
// - Config4 bit 5 picks clamp pin edge.
// - Config4 bit 4 picks digital input edge.
// - Config4 bits 3:2 give converter clock range.
// - Serializer equals converter clock; six-channel doubles pixel.
// - Config4 bit 1 low enables three-phase sampling.
// - Config4 bit 0 doubles converter and serializer clocks.
// - Config5 bit 7 picks internal or pin sampling.
// - Soft reset bit 1 resets state machines only.
// - Soft reset bit 0 resets registers too.
// - Revision register is read-only fixed code.
// - Gain code sets gain 283/(283-code).
// - Coarse offset code is five-bit offset binary.
// - Eleven-bit fine offset split over two registers.
`timescale 1ns/1ps
`include "afe_params.svh"
module afe_config_regs #(
  parameter logic [7:0] REVISION_CODE = 8'h5C, // Arbitrary value, set per silicon.
  parameter int         DIG_PINS      = 4
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_i,
  input  wire afe_pkg::reg_req_s     req_i,
  input  wire logic                  six_channel_mode_i,
  input  wire logic                  clamp_input_pin_i,
  input  wire logic [DIG_PINS-1:0]   digital_pins_i,
  output logic      [7:0]            rdata_o,
  output logic                       rdata_valid_o,
  output logic                       clamp_divider_en_o,
  output logic                       reference_buffer_powerdown_o,
  output logic                       clamp_input_pin_o,
  output logic      [DIG_PINS-1:0]   digital_pins_o,
  output afe_pkg::clock_range_e      clock_range_o,
  output logic                       three_phase_sample_mode_o,
  output logic      [1:0]            converter_clock_ratio_o,
  output logic      [1:0]            serializer_clock_ratio_o,
  output logic      [1:0]            pixel_ratio_o,
  output logic                       internal_dll_sampling_o,
  output logic                       fsm_reset_o,
  output logic      [7:0]            red_one_gain_o,
  output logic      [4:0]            red_one_coarse_offset_o,
  output logic      [10:0]           red_one_fine_offset_o,
  output logic      [7:0]            red_two_gain_o
);

  initial begin
    if (DIG_PINS < 1) begin
      $error("afe_config_regs needs at least one digital input pin");
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic afe_pkg::clock_range_e decode_range(input logic [1:0] code);
    afe_pkg::clock_range_e r;
    if (code[1]) begin
      r = afe_pkg::RANGE_10_20;
    end else if (code[0]) begin
      r = afe_pkg::RANGE_20_40;
    end else begin
      r = afe_pkg::RANGE_40_65;
    end
    return r;
  endfunction : decode_range

  function automatic logic [7:0] read_mux(input afe_pkg::bank_state_s s,
                                          input logic [7:0] addr);
    logic [7:0] d;
    d = 8'h00;
    if (addr == `AFE_ADDR_CFG4) begin
      d = s.cfg4;
    end else if (addr == `AFE_ADDR_CFG5) begin
      d = s.cfg5;
    end else if (addr == `AFE_ADDR_REVISION) begin
      d = REVISION_CODE;
    end else if (addr == `AFE_ADDR_R1_GAIN) begin
      d = s.r1_gain;
    end else if (addr == `AFE_ADDR_R1_COARSE) begin
      d = {3'h0, s.r1_coarse};
    end else if (addr == `AFE_ADDR_R1_FINE_HIGH) begin
      d = s.r1_fine_high;
    end else if (addr == `AFE_ADDR_R1_FINE_LOW) begin
      d = {s.r1_fine_low, 5'h00};
    end else if (addr == `AFE_ADDR_R2_GAIN) begin
      d = s.r2_gain;
    end
    // The soft reset register self-clears, so it and unmapped addresses read zero.
    return d;
  endfunction : read_mux

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.

  afe_pkg::bank_state_s state_r;
  afe_pkg::bank_state_s state_nxt;
  logic                 reg_reset;
  logic [1:0]           range_code;

  always_comb begin
    state_nxt           = state_r;
    reg_reset           = 1'b0;
    range_code          = 2'h0;
    state_nxt.fsm_reset = 1'b0;
    state_nxt.rd_valid  = req_i.rd;
    if (req_i.rd) begin
      state_nxt.rdata = read_mux(state_r, req_i.addr);
    end
    if (req_i.wr) begin
      if (req_i.addr == `AFE_ADDR_CFG4) begin
        state_nxt.cfg4 = req_i.wdata;
      end else if (req_i.addr == `AFE_ADDR_CFG5) begin
        // Reserved low bits are stored as written; the host keeps them at default.
        state_nxt.cfg5 = req_i.wdata;
      end else if (req_i.addr == `AFE_ADDR_SOFT_RESET) begin
        reg_reset           = req_i.wdata[`AFE_SRST_REG_BIT];
        state_nxt.fsm_reset = req_i.wdata[`AFE_SRST_FSM_BIT] | reg_reset;
      end else if (req_i.addr == `AFE_ADDR_R1_GAIN) begin
        state_nxt.r1_gain = req_i.wdata;
      end else if (req_i.addr == `AFE_ADDR_R1_COARSE) begin
        state_nxt.r1_coarse = req_i.wdata[4:0];
      end else if (req_i.addr == `AFE_ADDR_R1_FINE_HIGH) begin
        state_nxt.r1_fine_high = req_i.wdata;
      end else if (req_i.addr == `AFE_ADDR_R1_FINE_LOW) begin
        state_nxt.r1_fine_low = req_i.wdata[`AFE_FINE_LOW_HI:`AFE_FINE_LOW_LO];
      end else if (req_i.addr == `AFE_ADDR_R2_GAIN) begin
        state_nxt.r2_gain = req_i.wdata;
      end
      // A write to the revision address falls through and changes nothing.
    end
    if (reg_reset) begin
      // The request port belongs to the serial interface and is not reset here.
      state_nxt.cfg4         = `AFE_RST_CFG4;
      state_nxt.cfg5         = `AFE_RST_CFG5;
      state_nxt.r1_gain      = `AFE_RST_GAIN;
      state_nxt.r1_coarse    = `AFE_RST_COARSE;
      state_nxt.r1_fine_high = `AFE_RST_FINE_HIGH;
      state_nxt.r1_fine_low  = `AFE_RST_FINE_LOW;
      state_nxt.r2_gain      = `AFE_RST_GAIN;
    end
    range_code      = {state_nxt.cfg4[`AFE_CFG4_RANGE_HI], state_nxt.cfg4[`AFE_CFG4_RANGE_LO]};
    state_nxt.range = decode_range(range_code);
    // One ratio feeds both clocks so they can never differ in frequency.
    state_nxt.conv_ratio = state_nxt.cfg4[`AFE_CFG4_DOUBLER_BIT] ?
                           `AFE_RATIO_DOUBLE : `AFE_RST_RATIO;
    state_nxt.pixel_ratio = six_channel_mode_i ? `AFE_RATIO_DOUBLE : `AFE_RST_RATIO;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_r              <= '0;
      state_r.cfg4         <= `AFE_RST_CFG4;
      state_r.cfg5         <= `AFE_RST_CFG5;
      state_r.r1_gain      <= `AFE_RST_GAIN;
      state_r.r1_coarse    <= `AFE_RST_COARSE;
      state_r.r1_fine_high <= `AFE_RST_FINE_HIGH;
      state_r.r1_fine_low  <= `AFE_RST_FINE_LOW;
      state_r.r2_gain      <= `AFE_RST_GAIN;
      // Matches the range that the config4 reset value decodes to.
      state_r.range        <= afe_pkg::RANGE_40_65;
      state_r.conv_ratio   <= `AFE_RATIO_DOUBLE;
      state_r.pixel_ratio  <= `AFE_RST_RATIO;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin sampling on the selected master clock edge.

  logic                clamp_sampled;
  logic [DIG_PINS-1:0] dig_sampled;

  pin_edge_sampler #(
    .WIDTH (1)
  ) u_clamp_sampler (
    .ref_clk_i     (ref_clk_i),
    .reset_i       (reset_i),
    .pin_i         (clamp_input_pin_i),
    .falling_sel_i (state_r.cfg4[`AFE_CFG4_CLAMP_EDGE]),
    .sampled_o     (clamp_sampled)
  );

  pin_edge_sampler #(
    .WIDTH (DIG_PINS)
  ) u_digital_sampler (
    .ref_clk_i     (ref_clk_i),
    .reset_i       (reset_i),
    .pin_i         (digital_pins_i),
    .falling_sel_i (state_r.cfg4[`AFE_CFG4_DIG_EDGE]),
    .sampled_o     (dig_sampled)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all taken from flip-flops.

  assign rdata_o                      = state_r.rdata;
  assign rdata_valid_o                = state_r.rd_valid;
  assign clamp_divider_en_o           = state_r.cfg4[`AFE_CFG4_DIVIDER_BIT];
  assign reference_buffer_powerdown_o = state_r.cfg4[`AFE_CFG4_REFPD_BIT];
  assign clamp_input_pin_o            = clamp_sampled;
  assign digital_pins_o               = dig_sampled;
  assign clock_range_o                = state_r.range;
  // The bit disables the mode, so the enable is its inverse.
  assign three_phase_sample_mode_o    = ~state_r.cfg4[`AFE_CFG4_SH3_OFF_BIT];
  assign converter_clock_ratio_o      = state_r.conv_ratio;
  assign serializer_clock_ratio_o     = state_r.conv_ratio;
  assign pixel_ratio_o                = state_r.pixel_ratio;
  assign internal_dll_sampling_o      = state_r.cfg5[`AFE_CFG5_DLL_BIT];
  assign fsm_reset_o                  = state_r.fsm_reset;
  assign red_one_gain_o               = state_r.r1_gain;
  assign red_one_coarse_offset_o      = state_r.r1_coarse;
  assign red_one_fine_offset_o        = {state_r.r1_fine_high, state_r.r1_fine_low};
  assign red_two_gain_o               = state_r.r2_gain;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_divider_follows_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == `AFE_ADDR_CFG4 && !req_i.rd
    |=> clamp_divider_en_o == $past(req_i.wdata[`AFE_CFG4_DIVIDER_BIT]))
    else $error("clamp divider enable does not follow config4 write");

  a_refbuf_follows_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == `AFE_ADDR_CFG4
    |=> reference_buffer_powerdown_o == $past(req_i.wdata[`AFE_CFG4_REFPD_BIT]))
    else $error("reference buffer power down does not follow config4 write");

  a_range_decode_ok: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == `AFE_ADDR_CFG4 && req_i.wdata[3:2] == 2'h1
    |=> clock_range_o == afe_pkg::RANGE_20_40)
    else $error("clock range code 01 not decoded as 20-40 MHz");

  a_range_outer_bands: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == `AFE_ADDR_CFG4 && req_i.wdata[3:2] != 2'h1
    |=> clock_range_o == ($past(req_i.wdata[3]) ? afe_pkg::RANGE_10_20 : afe_pkg::RANGE_40_65))
    else $error("clock range codes 00 or 1x decoded wrongly");

  a_clocks_same_ratio: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    converter_clock_ratio_o == serializer_clock_ratio_o)
    else $error("converter and serializer clock ratios differ");

  a_pixel_ratio_mode: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    six_channel_mode_i |=> pixel_ratio_o == `AFE_RATIO_DOUBLE)
    else $error("pixel ratio not doubled in six-channel mode");

  a_sh3_inverse_bit: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == `AFE_ADDR_CFG4
    |=> three_phase_sample_mode_o == !$past(req_i.wdata[`AFE_CFG4_SH3_OFF_BIT]))
    else $error("three-phase mode enable is not the inverse of its bit");

  a_doubler_ratio: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == `AFE_ADDR_CFG4 && !req_i.wdata[`AFE_CFG4_DOUBLER_BIT]
    |=> converter_clock_ratio_o == `AFE_RST_RATIO)
    else $error("converter clock not at master clock with doubler off");

  a_doubler_on_ratio: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == `AFE_ADDR_CFG4 && req_i.wdata[`AFE_CFG4_DOUBLER_BIT]
    |=> converter_clock_ratio_o == `AFE_RATIO_DOUBLE)
    else $error("converter clock not doubled with doubler on");

  a_dll_select: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == `AFE_ADDR_CFG5
    |=> internal_dll_sampling_o == $past(req_i.wdata[`AFE_CFG5_DLL_BIT]))
    else $error("sampling clock source does not follow config5 write");

  a_fsm_reset_keeps: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == `AFE_ADDR_SOFT_RESET && req_i.wdata[1:0] == 2'h2
    |=> fsm_reset_o && $stable(red_one_gain_o) && $stable(state_r.cfg4))
    else $error("state machine reset missing or registers disturbed");

  a_fsm_pulse_only: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    fsm_reset_o
    |-> $past(req_i.wr && req_i.addr == `AFE_ADDR_SOFT_RESET
              && (req_i.wdata[`AFE_SRST_FSM_BIT] || req_i.wdata[`AFE_SRST_REG_BIT])))
    else $error("state machine reset pulse without a soft reset write");

  a_reg_reset_defaults: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == `AFE_ADDR_SOFT_RESET && req_i.wdata[`AFE_SRST_REG_BIT]
    |=> fsm_reset_o && state_r.cfg4 == `AFE_RST_CFG4
        && red_one_fine_offset_o == {`AFE_RST_FINE_HIGH, `AFE_RST_FINE_LOW})
    else $error("register reset did not restore defaults");

  a_revision_fixed: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req_i.rd && req_i.addr == `AFE_ADDR_REVISION |=> rdata_valid_o && rdata_o == REVISION_CODE)
    else $error("revision read returned the wrong code");

  a_revision_write_ignored: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == `AFE_ADDR_REVISION
    |=> $stable(red_one_gain_o) && $stable(red_two_gain_o) && $stable(state_r.cfg4)
        && $stable(state_r.cfg5) && $stable(red_one_fine_offset_o) && !fsm_reset_o)
    else $error("write to revision register altered state");

  a_fine_low_split: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == `AFE_ADDR_R1_FINE_LOW
    |=> red_one_fine_offset_o[2:0] == $past(req_i.wdata[7:5]))
    else $error("fine offset low bits not taken from bits 7:5");

  a_coarse_five_bits: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req_i.rd && req_i.addr == `AFE_ADDR_R1_COARSE |=> rdata_o[7:5] == 3'h0)
    else $error("coarse offset upper bits read non-zero");

  a_gain_stored: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == `AFE_ADDR_R2_GAIN |=> red_two_gain_o == $past(req_i.wdata))
    else $error("red channel 2 gain not stored");

endmodule : afe_config_regs

//--- afe_params.svh
// Register map, reset values and field positions of the front-end configuration bank.
`ifndef AFE_PARAMS_SVH
`define AFE_PARAMS_SVH

`define AFE_ADDR_CFG4          8'h04
`define AFE_ADDR_CFG5          8'h05
`define AFE_ADDR_SOFT_RESET    8'h06
`define AFE_ADDR_REVISION      8'h07
`define AFE_ADDR_R1_GAIN       8'h08
`define AFE_ADDR_R1_COARSE     8'h09
`define AFE_ADDR_R1_FINE_HIGH  8'h0A
`define AFE_ADDR_R1_FINE_LOW   8'h0B
`define AFE_ADDR_R2_GAIN       8'h0C

`define AFE_RST_CFG4           8'h83
`define AFE_RST_CFG5           8'hF7
`define AFE_RST_GAIN           8'h00
`define AFE_RST_COARSE         5'h10
`define AFE_RST_FINE_HIGH      8'h80
`define AFE_RST_FINE_LOW       3'h0
`define AFE_RST_RATIO          2'h1
`define AFE_RATIO_DOUBLE       2'h2

`define AFE_CFG4_DIVIDER_BIT   7
`define AFE_CFG4_REFPD_BIT     6
`define AFE_CFG4_CLAMP_EDGE    5
`define AFE_CFG4_DIG_EDGE      4
`define AFE_CFG4_RANGE_HI      3
`define AFE_CFG4_RANGE_LO      2
`define AFE_CFG4_SH3_OFF_BIT   1
`define AFE_CFG4_DOUBLER_BIT   0
`define AFE_CFG5_DLL_BIT       7
`define AFE_SRST_FSM_BIT       1
`define AFE_SRST_REG_BIT       0
`define AFE_FINE_LOW_HI        7
`define AFE_FINE_LOW_LO        5

`endif

//--- afe_pkg.sv
// Types shared by the front-end configuration bank and its host model.
package afe_pkg;

  typedef enum logic [1:0] {
    RANGE_40_65,
    RANGE_20_40,
    RANGE_10_20
  } clock_range_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [7:0]   cfg4;
    logic [7:0]   cfg5;
    logic [7:0]   r1_gain;
    logic [4:0]   r1_coarse;
    logic [7:0]   r1_fine_high;
    logic [2:0]   r1_fine_low;
    logic [7:0]   r2_gain;
    clock_range_e range;
    logic [1:0]   conv_ratio;
    logic [1:0]   pixel_ratio;
    logic         fsm_reset;
    logic         rd_valid;
    logic [7:0]   rdata;
  } bank_state_s;

  typedef struct packed {
    logic [1:0] rise_sync;
    logic [1:0] fall_sync;
    logic       sampled;
  } sampler_state_s;

endpackage : afe_pkg

//--- host_model.sv
// Host-side model that issues register writes and reads to the configuration bank.
`timescale 1ns/1ps
module host_model (
  input  wire logic              ref_clk_i,
  input  wire logic [7:0]        rdata_i,
  input  wire logic              rdata_valid_i,
  output afe_pkg::reg_req_s      req_o
);
  initial req_o = '0;

  // Reserved low bits of config5 are always sent with their power-on values.
  function automatic logic [7:0] cfg5_word(input logic dll);
    return {dll, 7'h77};
  endfunction : cfg5_word

  // Released lines show the inverse of the last word so stale data never passes for valid.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge ref_clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge ref_clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge ref_clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hFF};
    #1;
    data = rdata_valid_i ? rdata_i : 8'hXX;
  endtask : read_reg
endmodule : host_model

//--- pin_edge_sampler.sv
// Samples one group of pins on the rising or falling master clock edge.
`timescale 1ns/1ps
module pin_edge_sampler #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] pin_i,
  input  wire logic             falling_sel_i,
  output logic      [WIDTH-1:0] sampled_o
);

  initial begin
    if (WIDTH < 1) begin
      $error("pin_edge_sampler needs at least one pin");
    end
  end

  // The falling-edge capture is the first stage of its synchroniser.
  logic [WIDTH-1:0] fall_cap_r;
  logic [WIDTH-1:0] rise_s1_r;
  logic [WIDTH-1:0] rise_s2_r;
  logic [WIDTH-1:0] fall_s2_r;
  logic [WIDTH-1:0] sampled_r;

  always_ff @(negedge ref_clk_i) begin
    if (reset_i) begin
      fall_cap_r <= '0;
    end else begin
      fall_cap_r <= pin_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rise_s1_r <= '0;
      rise_s2_r <= '0;
      fall_s2_r <= '0;
      sampled_r <= '0;
    end else begin
      rise_s1_r <= pin_i;
      rise_s2_r <= rise_s1_r;
      fall_s2_r <= fall_cap_r;
      sampled_r <= falling_sel_i ? fall_s2_r : rise_s2_r;
    end
  end

  assign sampled_o = sampled_r;

endmodule : pin_edge_sampler

//--- tb.sv
// Self-checking testbench for the front-end configuration bank.
`timescale 1ns/1ps
`include "afe_params.svh"
module tb;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary revision value for this run.
  logic                  ref_clk_i;
  logic                  reset_i;
  afe_pkg::reg_req_s     req;
  logic                  six_ch;
  logic                  clamp_pin;
  logic [3:0]            dig_pins;
  logic [7:0]            rdata;
  logic                  rvalid, div_en, refpd, clamp_q, three_ph, dll, fsm_rst;
  logic [3:0]            dig_q;
  afe_pkg::clock_range_e range;
  logic [1:0]            conv_r, ser_r, pix_r;
  logic [7:0]            gain1, gain2;
  logic [4:0]            coarse;
  logic [10:0]           fine;
  int                    num_errors = 0;
  int                    total_checks = 0;
  int                    cycles = 0;

  afe_config_regs #(.REVISION_CODE(REV), .DIG_PINS(4)) dut_u (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_i(req), .six_channel_mode_i(six_ch),
    .clamp_input_pin_i(clamp_pin), .digital_pins_i(dig_pins), .rdata_o(rdata),
    .rdata_valid_o(rvalid), .clamp_divider_en_o(div_en), .reference_buffer_powerdown_o(refpd),
    .clamp_input_pin_o(clamp_q), .digital_pins_o(dig_q), .clock_range_o(range),
    .three_phase_sample_mode_o(three_ph), .converter_clock_ratio_o(conv_r),
    .serializer_clock_ratio_o(ser_r), .pixel_ratio_o(pix_r), .internal_dll_sampling_o(dll),
    .fsm_reset_o(fsm_rst), .red_one_gain_o(gain1), .red_one_coarse_offset_o(coarse),
    .red_one_fine_offset_o(fine), .red_two_gain_o(gain2));

  host_model host_u (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .rdata_valid_i(rvalid),
    .req_o(req));

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // A hang is cut short well above the roughly 80 cycles the sequence needs.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd_chk(input string what, input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host_u.read_reg(addr, d);
    chk(what, exp, d);
  endtask : rd_chk

  task automatic chk_cfg4(input logic [7:0] v);
    afe_pkg::clock_range_e r;
    r = v[3] ? afe_pkg::RANGE_10_20 : (v[2] ? afe_pkg::RANGE_20_40 : afe_pkg::RANGE_40_65);
    chk("divider", v[7], div_en);
    chk("refpd", v[6], refpd);
    chk("range", r, range);
    chk("three_phase", !v[1], three_ph);
    chk("conv_ratio", v[0] ? 2'h2 : 2'h1, conv_r);
    chk("ser_ratio", v[0] ? 2'h2 : 2'h1, ser_r);
  endtask : chk_cfg4

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    chk_cfg4(`AFE_RST_CFG4);
    chk("dll", 1'b1, dll);
    chk("gain1", 8'h00, gain1);
    chk("coarse", 5'h10, coarse);
    chk("fine", 11'h400, fine);
    rd_chk("cfg4", `AFE_ADDR_CFG4, 8'h83);
    rd_chk("cfg5", `AFE_ADDR_CFG5, 8'hF7);
    rd_chk("revision", `AFE_ADDR_REVISION, REV);
  endtask : t_defaults

  task automatic t_cfg4();
    logic [7:0] vals [4] = '{8'h00, 8'h45, 8'hBA, 8'hFF};
    foreach (vals[i]) begin
      host_u.write_reg(`AFE_ADDR_CFG4, vals[i]);
      #1;
      chk_cfg4(vals[i]);
      rd_chk("cfg4", `AFE_ADDR_CFG4, vals[i]);
    end
  endtask : t_cfg4

  task automatic t_six();
    @(posedge ref_clk_i) six_ch <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("pixel_ratio", 2'h2, pix_r);
    @(posedge ref_clk_i) six_ch <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("pixel_ratio", 2'h1, pix_r);
  endtask : t_six

  task automatic t_cfg5();
    host_u.write_reg(`AFE_ADDR_CFG5, host_u.cfg5_word(1'b0));
    #1;
    chk("dll", 1'b0, dll);
    rd_chk("cfg5", `AFE_ADDR_CFG5, 8'h77);
    host_u.write_reg(`AFE_ADDR_CFG5, host_u.cfg5_word(1'b1));
    #1;
    chk("dll", 1'b1, dll);
  endtask : t_cfg5

  task automatic t_chan();
    host_u.write_reg(`AFE_ADDR_R1_GAIN, 8'hFF);
    host_u.write_reg(`AFE_ADDR_R1_COARSE, 8'hFF);
    host_u.write_reg(`AFE_ADDR_R1_FINE_HIGH, 8'h5A);
    host_u.write_reg(`AFE_ADDR_R1_FINE_LOW, 8'hBF);
    host_u.write_reg(`AFE_ADDR_R2_GAIN, 8'hC5);
    #1;
    chk("gain1", 8'hFF, gain1);
    chk("gain2", 8'hC5, gain2);
    chk("coarse", 5'h1F, coarse);
    chk("fine", {8'h5A, 3'h5}, fine);
    rd_chk("coarse_rd", `AFE_ADDR_R1_COARSE, 8'h1F);
    rd_chk("fine_lo_rd", `AFE_ADDR_R1_FINE_LOW, 8'hA0);
  endtask : t_chan

  task automatic t_revision();
    host_u.write_reg(`AFE_ADDR_REVISION, ~REV);
    rd_chk("revision", `AFE_ADDR_REVISION, REV);
    rd_chk("cfg4", `AFE_ADDR_CFG4, 8'hFF);
    rd_chk("soft_reset_rd", `AFE_ADDR_SOFT_RESET, 8'h00);
    rd_chk("unmapped", 8'h30, 8'h00);
  endtask : t_revision

  task automatic t_soft();
    host_u.write_reg(`AFE_ADDR_R1_GAIN, 8'h11);
    host_u.write_reg(`AFE_ADDR_CFG5, host_u.cfg5_word(1'b0));
    host_u.write_reg(`AFE_ADDR_SOFT_RESET, 8'h02);
    #1;
    chk("fsm_reset", 1'b1, fsm_rst);
    chk("gain1", 8'h11, gain1);
    chk("dll", 1'b0, dll);
    chk_cfg4(8'hFF);
    @(posedge ref_clk_i);
    #1;
    chk("fsm_reset", 1'b0, fsm_rst);
    host_u.write_reg(`AFE_ADDR_SOFT_RESET, 8'h01);
    #1;
    chk("fsm_reset", 1'b1, fsm_rst);
    chk("gain1", 8'h00, gain1);
    chk("coarse", 5'h10, coarse);
    chk("fine", 11'h400, fine);
    chk("dll", 1'b1, dll);
    chk_cfg4(`AFE_RST_CFG4);
  endtask : t_soft

  // A one-cycle pin pulse shows up one cycle earlier through the falling-edge path,
  // so the cycle at which it appears tells which edge sampled it.
  task automatic t_pins(input logic [7:0] v);
    logic fc;
    logic fd;
    fc = v[`AFE_CFG4_CLAMP_EDGE];
    fd = v[`AFE_CFG4_DIG_EDGE];
    host_u.write_reg(`AFE_ADDR_CFG4, v);
    clamp_pin <= 1'b1;
    dig_pins <= 4'hA;
    @(posedge ref_clk_i);
    clamp_pin <= 1'b0;
    dig_pins <= 4'h0;
    @(posedge ref_clk_i);
    #1;
    chk("clamp_early", fc, clamp_q);
    chk("dig_early", fd ? 4'hA : 4'h0, dig_q);
    @(posedge ref_clk_i);
    #1;
    chk("clamp_late", !fc, clamp_q);
    chk("dig_late", fd ? 4'h0 : 4'hA, dig_q);
  endtask : t_pins

  initial begin
    reset_i = 1'b1;
    six_ch = 1'b0;
    clamp_pin = 1'b0;
    dig_pins = 4'h0;
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    t_defaults();
    t_cfg4();
    t_six();
    t_cfg5();
    t_chan();
    t_revision();
    t_soft();
    t_pins(8'hA3);
    t_pins(8'h93);
    summarize();
  end
endmodule : tb
